// ---- design/mspc_pkg.sv ----
// shared constants for the module static power and cable advertisement block
package mspc_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_POWER_CLASS = 10'h0c8;
  localparam logic [9:0] IDX_MAX_POWER = 10'h0c9;
  localparam logic [9:0] IDX_LINK_LENGTH = 10'h0ca;
  localparam logic [9:0] IDX_PLUG_KIND = 10'h0cb;
  localparam logic [9:0] IDX_LOSS_LOW = 10'h0cc;
  localparam logic [9:0] IDX_LOSS_SECOND = 10'h0cd;
  localparam logic [9:0] IDX_LOSS_THIRD = 10'h0ce;
  localparam logic [9:0] IDX_LOSS_HIGH = 10'h0cf;
  localparam logic [9:0] IDX_RESERVED_PAIR = 10'h0d0;
  localparam logic [9:0] IDX_LANE_BITMAP = 10'h0d2;
  localparam logic [9:0] IDX_OWN_CTRL = 10'h100;
  localparam logic [9:0] IDX_OWN_STATUS = 10'h101;

  // loader byte numbers match the register indices
  localparam logic [7:0] BYTE_POWER_CLASS = 8'hc8;
  localparam logic [7:0] BYTE_LINK_LENGTH = 8'hca;
  localparam logic [7:0] BYTE_PLUG_KIND = 8'hcb;
  localparam logic [7:0] BYTE_LOSS_LOW = 8'hcc;
  localparam logic [7:0] BYTE_LOSS_HIGH = 8'hcf;
  localparam logic [7:0] BYTE_LANE_BITMAP = 8'hd2;

  // storage slots
  localparam logic [2:0] SLOT_POWER = 3'h0;
  localparam logic [2:0] SLOT_LINK = 3'h1;
  localparam logic [2:0] SLOT_PLUG = 3'h2;
  localparam logic [2:0] SLOT_LOSS0 = 3'h3;
  localparam logic [2:0] SLOT_LANE = 3'h7;
  localparam int SLOT_COUNT = 8;

  // field positions
  localparam int CLASS_LSB = 5;
  localparam int SCALE_LSB = 6;
  localparam int BASE_MSB = 5;
  localparam int CTRL_HOLD_BIT = 0;
  localparam int STAT_OVER_BIT = 16;
  localparam int STAT_UNDEF_BIT = 17;
  localparam int STAT_SEP_BIT = 18;
  localparam int STAT_COPPER_BIT = 19;
  localparam int STAT_HOLD_BIT = 20;

  // reset values and codes
  localparam logic [7:0] ADV_RESET = 8'h00;
  localparam logic [7:0] LANE_RESET = 8'hff;
  localparam logic CTRL_HOLD_RESET = 1'b0;
  localparam logic [7:0] LEN_ALL_ONES = 8'hff;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // power quantisation, milliwatts per quarter watt
  localparam logic [16:0] QUARTER_WATT_MW = 17'h0_00fa;
  localparam logic [16:0] ROUND_UP_MW = 17'h0_00f9;
  localparam logic [16:0] MAX_UNITS = 17'h0_00ff;

  // length scale factors in decimetres
  localparam logic [9:0] SCALE_TENTH = 10'h001;
  localparam logic [9:0] SCALE_ONE = 10'h00a;
  localparam logic [9:0] SCALE_TEN = 10'h064;
  localparam logic [9:0] SCALE_HUNDRED = 10'h3e8;

endpackage

// ---- design/mspc_power_quant.sv ----
// converts worst-case milliwatts to quarter-watt units, rounded up
`timescale 1ns/10ps
module mspc_power_quant
  import mspc_pkg::*;
(
  input wire logic [15:0] worst_mw,
  output logic [7:0] units
);

  logic [16:0] sum;
  logic [16:0] quot;

  // ceiling divide, saturate at the byte limit
  assign sum = {1'b0, worst_mw} + ROUND_UP_MW;
  assign quot = sum / QUARTER_WATT_MW;
  assign units = (quot > MAX_UNITS) ? 8'hff : quot[7:0];

endmodule

// ---- design/mspc_link_decode.sv ----
// decodes the link length byte into decimetres and flags
`timescale 1ns/10ps
module mspc_link_decode
  import mspc_pkg::*;
(
  input wire logic [7:0] link_byte,
  output logic [15:0] length_dm,
  output logic over_6300,
  output logic undefined
);

  logic [1:0] length_scale_select;
  logic [5:0] length_base_value;

  // scale code to decimetre factor
  function automatic logic [9:0] scale_factor(input logic [1:0] code);
    case (code)
      2'b00: scale_factor = SCALE_TENTH;
      2'b01: scale_factor = SCALE_ONE;
      2'b10: scale_factor = SCALE_TEN;
      default: scale_factor = SCALE_HUNDRED;
    endcase
  endfunction

  assign length_scale_select = link_byte[7:SCALE_LSB];
  assign length_base_value = link_byte[BASE_MSB:0];
  // all ones is a flag, not a coded length
  assign over_6300 = (link_byte == LEN_ALL_ONES);
  assign undefined = (length_base_value == 6'h00) && !over_6300;
  // base times multiplier
  assign length_dm = over_6300 ? 16'h0000 :
    16'({10'h000, length_base_value} * {6'h00, scale_factor(length_scale_select)});

endmodule

// ---- design/mspc_adv_bank.sv ----
// read-only advertisement bank for power, cable length, connector, loss and lanes
`timescale 1ns/10ps
module mspc_adv_bank
  import mspc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic adv_load_valid,
  output logic adv_load_ready,
  input wire logic [7:0] adv_load_byte,
  input wire logic [7:0] adv_load_data,
  input wire logic [15:0] worst_power_mw,
  input wire logic media_separable,
  input wire logic passive_copper
);

  typedef struct packed {
    logic [SLOT_COUNT-1:0][7:0] adv;
    logic hold;
    logic [7:0] max_power;
    logic [31:0] rdata;
    logic slverr;
  } mspc_state_type;

  localparam mspc_state_type ST_RESET = '{
    adv: {LANE_RESET, {(SLOT_COUNT-1){ADV_RESET}}},
    hold: CTRL_HOLD_RESET,
    max_power: ADV_RESET,
    rdata: WORD_ZERO,
    slverr: 1'b0
  };

  mspc_state_type st_ff;
  mspc_state_type nxt_st;
  logic [9:0] idx;
  logic [7:0] quant_units;
  logic [7:0] link_eff;
  logic [15:0] length_dm;
  logic over_6300;
  logic length_undef;
  logic [31:0] status_word;
  logic load_fire;
  logic setup_phase;
  logic access_phase;

  // address mapping
  function automatic logic is_mapped(input logic [9:0] i);
    case (i)
      IDX_POWER_CLASS, IDX_MAX_POWER, IDX_LINK_LENGTH, IDX_PLUG_KIND,
      IDX_LOSS_LOW, IDX_LOSS_SECOND, IDX_LOSS_THIRD, IDX_LOSS_HIGH,
      IDX_RESERVED_PAIR, IDX_LANE_BITMAP, IDX_OWN_CTRL, IDX_OWN_STATUS: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // loader byte number to storage slot; bytes 201 and 208-209 have no slot
  function automatic logic [3:0] slot_of(input logic [7:0] b);
    logic [7:0] off;
    off = b - BYTE_LOSS_LOW;
    if (b == BYTE_POWER_CLASS) begin
      slot_of = {1'b1, SLOT_POWER};
    end else if (b == BYTE_LINK_LENGTH) begin
      slot_of = {1'b1, SLOT_LINK};
    end else if (b == BYTE_PLUG_KIND) begin
      slot_of = {1'b1, SLOT_PLUG};
    end else if (b >= BYTE_LOSS_LOW && b <= BYTE_LOSS_HIGH) begin
      slot_of = {1'b1, SLOT_LOSS0 + off[2:0]};
    end else if (b == BYTE_LANE_BITMAP) begin
      slot_of = {1'b1, SLOT_LANE};
    end else begin
      slot_of = 4'h0;
    end
  endfunction

  assign idx = paddr[11:2];
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;

  // worst-case power from the device's own budget input
  mspc_power_quant u_quant (
    .worst_mw(worst_power_mw),
    .units(quant_units)
  );

  // separable media force the length to zero before decoding
  assign link_eff = media_separable ? ADV_RESET : st_ff.adv[SLOT_LINK];

  mspc_link_decode u_decode (
    .link_byte(link_eff),
    .length_dm(length_dm),
    .over_6300(over_6300),
    .undefined(length_undef)
  );

  // status word shows decoded length and the live configuration
  always_comb begin
    status_word = WORD_ZERO;
    status_word[15:0] = length_dm;
    status_word[STAT_OVER_BIT] = over_6300;
    status_word[STAT_UNDEF_BIT] = length_undef;
    status_word[STAT_SEP_BIT] = media_separable;
    status_word[STAT_COPPER_BIT] = passive_copper;
    status_word[STAT_HOLD_BIT] = st_ff.hold;
  end

  // the loader is stalled while software holds updates
  assign adv_load_ready = !st_ff.hold;
  assign load_fire = adv_load_valid && adv_load_ready;

  // zero-wait slave: data is captured in setup and stands through access
  assign pready = 1'b1;
  assign prdata = st_ff.rdata;
  assign pslverr = st_ff.slverr;

  // next-state logic
  always_comb begin
    logic [3:0] slot;
    slot = slot_of(adv_load_byte);
    nxt_st = st_ff;
    nxt_st.max_power = quant_units;
    nxt_st.slverr = 1'b0;
    if (setup_phase) begin
      nxt_st.slverr = !is_mapped(idx);
      nxt_st.rdata = WORD_ZERO;
      case (idx)
        IDX_POWER_CLASS: nxt_st.rdata[7:0] = {st_ff.adv[SLOT_POWER][7:CLASS_LSB], 5'h00};
        IDX_MAX_POWER: nxt_st.rdata[7:0] = st_ff.max_power;
        IDX_LINK_LENGTH: nxt_st.rdata[7:0] = link_eff;
        IDX_PLUG_KIND: nxt_st.rdata[7:0] = st_ff.adv[SLOT_PLUG];
        IDX_LOSS_LOW, IDX_LOSS_SECOND, IDX_LOSS_THIRD, IDX_LOSS_HIGH: begin
          // loss figures only for passive copper
          if (passive_copper) begin
            nxt_st.rdata[7:0] = st_ff.adv[SLOT_LOSS0 + idx[2:0] - IDX_LOSS_LOW[2:0]];
          end else begin
            nxt_st.rdata[7:0] = ADV_RESET;
          end
        end
        IDX_RESERVED_PAIR: nxt_st.rdata = WORD_ZERO;
        IDX_LANE_BITMAP: nxt_st.rdata[7:0] = st_ff.adv[SLOT_LANE];
        IDX_OWN_CTRL: nxt_st.rdata[CTRL_HOLD_BIT] = st_ff.hold;
        IDX_OWN_STATUS: nxt_st.rdata = status_word;
        default: nxt_st.rdata = WORD_ZERO;
      endcase
    end
    // only the control word takes writes; advertisement writes are dropped
    if (access_phase && pwrite && idx == IDX_OWN_CTRL && pstrb[0]) begin
      nxt_st.hold = pwdata[CTRL_HOLD_BIT];
    end
    // device-side loader fills the advertised bytes
    if (load_fire && slot[3]) begin
      if (slot[2:0] == SLOT_POWER) begin
        nxt_st.adv[SLOT_POWER] = {adv_load_data[7:CLASS_LSB], 5'h00};
      end else begin
        nxt_st.adv[slot[2:0]] = adv_load_data;
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // a setup cycle on a given index followed by its access cycle
  sequence setup_on(logic [9:0] i);
    psel && !penable && idx == i;
  endsequence

  sequence access_next;
    ##1 (psel && penable);
  endsequence

  class_low_zero_a: assert property (setup_on(IDX_POWER_CLASS) |-> access_next ##0 prdata[4:0] == 5'h00)
    else $error("power class reserved bits not zero");

  max_power_round_a: assert property (##1 (($past(worst_power_mw) > 16'hf906) ?
    (st_ff.max_power == 8'hff) :
    ((int'(st_ff.max_power) * 250 >= int'($past(worst_power_mw))) &&
     (int'(st_ff.max_power) * 250 < int'($past(worst_power_mw)) + 250))))
    else $error("max power not rounded up to quarter watts");

  max_power_read_a: assert property (setup_on(IDX_MAX_POWER) |=> prdata[7:0] == $past(st_ff.max_power))
    else $error("max power read differs from worst-case figure");

  separable_zero_a: assert property ((setup_phase && idx == IDX_LINK_LENGTH && media_separable) |=>
    prdata == WORD_ZERO)
    else $error("separable media length not zero");

  over_flag_a: assert property ((link_eff == LEN_ALL_ONES) |-> over_6300 && length_dm == 16'h0000)
    else $error("all-ones length not flagged");

  scale_tenth_a: assert property ((link_eff[7:6] == 2'b00) |-> length_dm == {10'h000, link_eff[5:0]})
    else $error("tenth scale length wrong");

  base_undef_a: assert property ((link_eff[5:0] == 6'h00 && link_eff != LEN_ALL_ONES) |->
    length_undef && length_dm == 16'h0000)
    else $error("zero base not undefined");

  copper_gate_a: assert property ((psel && !penable && idx >= IDX_LOSS_LOW && idx <= IDX_RESERVED_PAIR
    && !passive_copper) |=> prdata == WORD_ZERO)
    else $error("non-copper loss bytes not reserved");

  lane_load_a: assert property ((load_fire && adv_load_byte == BYTE_LANE_BITMAP) |=>
    st_ff.adv[SLOT_LANE] == $past(adv_load_data))
    else $error("lane bitmap not loaded");

  ro_write_a: assert property ((access_phase && pwrite && idx != IDX_OWN_CTRL && !adv_load_valid) |=>
    $stable(st_ff.adv) && $stable(st_ff.hold))
    else $error("write changed read-only state");

  unmapped_err_a: assert property ((setup_phase && !is_mapped(idx)) |-> access_next ##0 pslverr)
    else $error("unmapped access without error");

  hold_stall_a: assert property ((st_ff.hold && !(access_phase && pwrite && idx == IDX_OWN_CTRL)) |->
    !adv_load_ready ##1 st_ff.hold)
    else $error("loader not stalled while held");

  // unit multiplier keeps the base in whole meters
  scale_one_a: assert property ((link_eff[7:6] == 2'b01) |->
    int'(length_dm) == int'(link_eff[5:0]) * 10)
    else $error("unit scale length wrong");

  // ten times multiplier
  scale_ten_a: assert property ((link_eff[7:6] == 2'b10) |->
    int'(length_dm) == int'(link_eff[5:0]) * 100)
    else $error("ten scale length wrong");

  // hundred times multiplier, all ones excluded
  scale_hundred_a: assert property (((link_eff[7:6] == 2'b11) && link_eff != LEN_ALL_ONES) |->
    int'(length_dm) == int'(link_eff[5:0]) * 1000)
    else $error("hundred scale length wrong");

  // connector code reads back as stored
  plug_read_a: assert property (setup_on(IDX_PLUG_KIND) |=>
    prdata == {24'h00_0000, $past(st_ff.adv[SLOT_PLUG])})
    else $error("connector code read wrong");

  // copper loss reads back for passive copper
  loss_read_a: assert property ((setup_phase && idx == IDX_LOSS_LOW && passive_copper) |=>
    prdata == {24'h00_0000, $past(st_ff.adv[SLOT_LOSS0])})
    else $error("copper loss read wrong");

  // reserved pair always reads zero
  reserved_pair_a: assert property (setup_on(IDX_RESERVED_PAIR) |=>
    prdata == WORD_ZERO)
    else $error("reserved pair not zero");

  // lane bitmap reads back as stored
  lane_read_a: assert property (setup_on(IDX_LANE_BITMAP) |=>
    prdata == {24'h00_0000, $past(st_ff.adv[SLOT_LANE])})
    else $error("lane bitmap read wrong");

  // power byte keeps only the class code
  power_load_a: assert property ((load_fire && adv_load_byte == BYTE_POWER_CLASS) |=>
    st_ff.adv[SLOT_POWER] == {$past(adv_load_data[7:CLASS_LSB]), 5'h00})
    else $error("power class not stored");

  // other loader bytes leave the lane bitmap alone
  lane_keep_a: assert property ((load_fire && adv_load_byte != BYTE_LANE_BITMAP) |=>
    $stable(st_ff.adv[SLOT_LANE]))
    else $error("lane bitmap disturbed");

  // max power comes from the budget input, never from the loader
  power_byte_drop_a: assert property ((load_fire && adv_load_byte == BYTE_POWER_CLASS + 8'h01) |=>
    $stable(st_ff.adv))
    else $error("loader changed storage for max power byte");

  // separable media show up as undefined zero length
  sep_status_a: assert property ((setup_phase && idx == IDX_OWN_STATUS && media_separable) |=>
    prdata[STAT_SEP_BIT] && prdata[STAT_UNDEF_BIT] && prdata[15:0] == 16'h0000)
    else $error("separable status wrong");

  // control write with its strobe sets the hold bit
  hold_write_a: assert property ((access_phase && pwrite && idx == IDX_OWN_CTRL && pstrb[0]) |=>
    st_ff.hold == $past(pwdata[CTRL_HOLD_BIT]))
    else $error("hold bit not written");

  // error stands for the access cycle only
  slverr_pulse_a: assert property (pslverr |=> !pslverr)
    else $error("error longer than one cycle");

  // read data stands until the next setup
  rdata_stand_a: assert property (!setup_phase |=> $stable(prdata))
    else $error("read data moved outside setup");

  // mapped accesses answer without error
  mapped_ok_a: assert property ((setup_phase && is_mapped(idx)) |-> access_next ##0 !pslverr)
    else $error("mapped access with error");

endmodule

// ---- tb/mspc_host_model.sv ----
// apb host model that reads the module management memory
`timescale 1ns/10ps
module mspc_host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
  end

  // setup, then access held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // released data does not keep the last value
  endtask
endmodule

// ---- tb/test_module_static_power_cable_info.sv ----
// self-checking bench for the static power and cable advertisement bank
`timescale 1ns/10ps
module test_module_static_power_cable_info
  import mspc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  logic adv_load_valid, adv_load_ready, media_separable, passive_copper, e;
  logic [7:0] adv_load_byte, adv_load_data;
  logic [15:0] worst_power_mw;
  int n_fail = 0;
  int total_checks = 0;

  mspc_adv_bank u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adv_load_valid(adv_load_valid), .adv_load_ready(adv_load_ready), .adv_load_byte(adv_load_byte),
    .adv_load_data(adv_load_data), .worst_power_mw(worst_power_mw), .media_separable(media_separable),
    .passive_copper(passive_copper));

  mspc_host_model u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // 250 MHz clock
  always #2 pclk = ~pclk;

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // read one register by index and compare its word
  task automatic rdchk(input logic [9:0] i, input logic [31:0] exp);
    u_host.xfer(1'b0, {i, 2'b00}, 32'h0000_0000, q, e);
    chk(q, exp);
    chk({31'h0000_0000, e}, 32'h0000_0000);
  endtask

  // store one byte through the loader, waiting while it stalls
  task automatic load(input logic [7:0] b, input logic [7:0] d);
    @(posedge pclk);
    adv_load_valid <= 1'b1;
    adv_load_byte <= b;
    adv_load_data <= d;
    do @(posedge pclk); while (adv_load_ready !== 1'b1);
    adv_load_valid <= 1'b0;
    adv_load_data <= ~d;
  endtask

  task automatic t_reset;
    rdchk(IDX_LANE_BITMAP, 32'h0000_00ff);
    rdchk(IDX_RESERVED_PAIR, WORD_ZERO);
    u_host.xfer(1'b0, 12'h344, WORD_ZERO, q, e);
    chk({31'h0000_0000, e}, 32'h0000_0001);
    chk(q, WORD_ZERO);
    $display("test reset done");
  endtask

  task automatic t_power;
    logic [15:0] mw [6] = '{16'h0000, 16'h0001, 16'h00fa, 16'h00fb, 16'hf906, 16'hf907};
    logic [7:0] un [6] = '{8'h00, 8'h01, 8'h01, 8'h02, 8'hff, 8'hff};
    load(BYTE_POWER_CLASS, 8'hff);
    rdchk(IDX_POWER_CLASS, 32'h0000_00e0);
    load(BYTE_POWER_CLASS, 8'h5f);
    rdchk(IDX_POWER_CLASS, 32'h0000_0040);
    for (int k = 0; k < 6; k++) begin
      @(posedge pclk);
      worst_power_mw <= mw[k];
      rdchk(IDX_MAX_POWER, {24'h00_0000, un[k]});
    end
    $display("test power done");
  endtask

  task automatic t_link;
    logic [7:0] lb [5] = '{8'h05, 8'h45, 8'h85, 8'hc5, 8'h80};
    logic [31:0] st [5] = '{32'h0000_0005, 32'h0000_0032, 32'h0000_01f4, 32'h0000_1388, 32'h0002_0000};
    for (int k = 0; k < 5; k++) begin
      load(BYTE_LINK_LENGTH, lb[k]);
      rdchk(IDX_LINK_LENGTH, {24'h00_0000, lb[k]});
      rdchk(IDX_OWN_STATUS, st[k]);
    end
    load(BYTE_LINK_LENGTH, LEN_ALL_ONES);
    u_host.xfer(1'b0, {IDX_OWN_STATUS, 2'b00}, WORD_ZERO, q, e);
    chk({31'h0000_0000, q[STAT_OVER_BIT]}, 32'h0000_0001);
    chk({16'h0000, q[15:0]}, WORD_ZERO);
    @(posedge pclk);
    media_separable <= 1'b1;
    rdchk(IDX_LINK_LENGTH, WORD_ZERO);
    rdchk(IDX_OWN_STATUS, 32'h0006_0000);
    @(posedge pclk);
    media_separable <= 1'b0;
    rdchk(IDX_LINK_LENGTH, 32'h0000_00ff);
    $display("test link done");
  endtask

  task automatic t_plug_loss;
    load(BYTE_PLUG_KIND, 8'h23);
    rdchk(IDX_PLUG_KIND, 32'h0000_0023);
    for (int k = 0; k < 4; k++) load(BYTE_LOSS_LOW + 8'(k), 8'h10 + 8'(k));
    @(posedge pclk);
    passive_copper <= 1'b1;
    for (int k = 0; k < 4; k++) rdchk(IDX_LOSS_LOW + 10'(k), 32'h0000_0010 + 32'(k));
    rdchk(IDX_RESERVED_PAIR, WORD_ZERO);
    rdchk(IDX_OWN_STATUS, 32'h0009_0000);
    @(posedge pclk);
    passive_copper <= 1'b0;
    for (int k = 0; k < 4; k++) rdchk(IDX_LOSS_LOW + 10'(k), WORD_ZERO);
    $display("test plug and loss done");
  endtask

  task automatic t_lane_ro;
    load(BYTE_LANE_BITMAP, 8'h81);
    rdchk(IDX_LANE_BITMAP, 32'h0000_0081);
    for (int k = 0; k < 11; k++) u_host.xfer(1'b1, {IDX_POWER_CLASS + 10'(k), 2'b00}, 32'hffff_ffff, q, e);
    rdchk(IDX_LANE_BITMAP, 32'h0000_0081);
    rdchk(IDX_PLUG_KIND, 32'h0000_0023);
    rdchk(IDX_POWER_CLASS, 32'h0000_0040);
    u_host.xfer(1'b1, {IDX_OWN_CTRL, 2'b00}, 32'h0000_0001, q, e);
    @(posedge pclk);
    chk({31'h0000_0000, adv_load_ready}, WORD_ZERO);
    // a load offered while held must not land
    @(posedge pclk);
    adv_load_valid <= 1'b1;
    adv_load_byte <= BYTE_LANE_BITMAP;
    adv_load_data <= 8'h3c;
    repeat (2) @(posedge pclk);
    adv_load_valid <= 1'b0;
    rdchk(IDX_LANE_BITMAP, 32'h0000_0081);
    rdchk(IDX_OWN_CTRL, 32'h0000_0001);
    rdchk(IDX_OWN_STATUS, 32'h0011_0000);
    u_host.xfer(1'b1, {IDX_OWN_CTRL, 2'b00}, WORD_ZERO, q, e);
    $display("test lanes and writes done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog, far beyond the 56 transfers of the run
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    report_and_stop;
  end

  // reset, then the scenarios in turn
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    adv_load_valid = 1'b0;
    adv_load_byte = 8'h00;
    adv_load_data = 8'h00;
    worst_power_mw = 16'h0000;
    media_separable = 1'b0;
    passive_copper = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_power;
    t_link;
    t_plug_loss;
    t_lane_ro;
    report_and_stop;
  end
endmodule
